// ===== verilog/urg_rxcmd_gen.sv
// Receive command byte generator with AXI4-Lite register access.
//
// Operation
// - Send only in sync mode, owning bus.
// - Line state change with DIR low: send.
// - Receive: status byte when DIR=1, NXT=0.
// - Transmit: status bytes only after STP.
// - VBUS or ID change sends status byte.
// - Start-up: DIR released, STP low: send.
// - Mode exit after STP: send byte.
// - Bits 1:0 carry line state.
// - Bits 3:2 carry encoded VBUS level.
// - Bits 5:4 carry receive event code.
// - Bit 6 copies ID level.
// - Bit 7 set on unmasked latched interrupt.
// - Bit0 follows D+, bit1 follows D-.
// - One turn-around cycle per DIR change.
// - DIR with NXT marks receive start.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module urg_rxcmd_gen
  import urg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire urg_status_t stat_in,
  input  wire logic        tx_active,
  input  wire logic        mode_exit,
  input  wire logic        rx_start,
  input  wire logic        rx_byte_vld,
  input  wire logic [7:0]  rx_byte,
  input  wire logic [ALT_W-1:0] alt_event,
  input  wire logic        stp,
  output logic             dir,
  output logic             nxt,
  output logic [7:0]       data_out,
  output logic             data_oe_n,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The alternate latch and its mask share one 32-bit register.
  if (ALT_W < 1 || ALT_W > 16) begin : g_alt_w_bad
    $error("alternate event width out of range");
  end
  if (IRQ_W != 3) begin : g_irq_w_bad
    $error("interrupt status width must be three");
  end

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_n_ff;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0]       ctrl_ff;
  logic [IRQ_W-1:0]  irq_st_ff;
  logic [IRQ_W-1:0]  irq_mask_ff;
  logic [ALT_W-1:0]  alt_latch_ff;
  logic [ALT_W-1:0]  alt_mask_ff;
  logic [7:0]        last_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  // ----------------------------------------------------------------
  // Status byte assembly
  // ----------------------------------------------------------------
  urg_rxcmd_t cur_cmd;
  logic [1:0] vb_enc;
  logic [1:0] rx_enc;
  assign vb_enc = stat_in.vbus_vld ? VB_VVLD :
                  stat_in.sess_vld ? VB_SVLD :
                  stat_in.sess_end ? VB_LOW  : VB_SEND;
  assign rx_enc = stat_in.host_disc ? RX_HDISC :
                  !stat_in.rx_active ? RX_IDLE :
                  stat_in.rx_error ? RX_ERR : RX_ACT;
  assign cur_cmd.line_state = {stat_in.dm, stat_in.dp};
  assign cur_cmd.vbus       = vb_enc;
  assign cur_cmd.rx_event   = rx_enc;
  assign cur_cmd.id         = stat_in.id;
  assign cur_cmd.alt_int    = |(alt_latch_ff & ~alt_mask_ff);

  // ----------------------------------------------------------------
  // Change detection and pending request
  // ----------------------------------------------------------------
  urg_rxcmd_t prev_ff;
  logic       pend_ff;
  logic       stp_seen_ff;
  logic       strt_ff;
  logic       sync_mode;
  logic       ls_chg;
  logic       vbid_chg;
  logic       oth_chg;
  logic       rx_mode;
  assign sync_mode = ctrl_ff[CTRL_SYNC];
  assign ls_chg    = cur_cmd.line_state != prev_ff.line_state;
  assign vbid_chg  = (cur_cmd.vbus != prev_ff.vbus) || (cur_cmd.id != prev_ff.id);
  assign oth_chg   = (cur_cmd.rx_event != prev_ff.rx_event) || (cur_cmd.alt_int != prev_ff.alt_int);
  assign rx_mode   = stat_in.rx_active;

  urg_state_t st_ff;
  logic       send_now;
  logic       want;
  logic       loading;
  // During transmit, requests wait until STP has been seen.
  assign want = (pend_ff || ls_chg || vbid_chg || oth_chg) &&
                (!tx_active || stp_seen_ff);
  assign send_now = (st_ff == ST_SEND);

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      prev_ff     <= '0;
      pend_ff     <= 1'b0;
      stp_seen_ff <= 1'b0;
      strt_ff     <= 1'b0;
    end else begin
      prev_ff     <= cur_cmd;
      stp_seen_ff <= tx_active ? (stp_seen_ff | stp) : 1'b0;
      strt_ff     <= strt_ff | (sync_mode && !stp);
      // A loaded byte already holds the latest values, so only an exit request survives the load.
      if (loading && !(mode_exit && stp)) begin
        pend_ff <= 1'b0;
      end else if (ls_chg || vbid_chg || oth_chg || (mode_exit && stp) || (sync_mode && !strt_ff && !stp)) begin
        pend_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus ownership sequencer
  // ----------------------------------------------------------------
  urg_state_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: begin
        if (sync_mode && (want || rx_start)) begin
          nxt_st = ST_TURN;
        end
      end
      ST_TURN: nxt_st = ST_SEND;
      ST_SEND: begin
        if (!rx_mode && !want) begin
          nxt_st = ST_REL;
        end
      end
      ST_REL:  nxt_st = ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  logic       dir_ff;
  logic       nxt_ff;
  logic [7:0] data_ff;
  logic       nxt_dir;
  logic       nxt_nxt;
  assign nxt_dir = (nxt_st == ST_TURN) || (nxt_st == ST_SEND);
  // A receive start shows DIR and NXT together on the turn cycle.
  assign nxt_nxt = ((nxt_st == ST_TURN) && rx_start) ||
                   ((nxt_st == ST_SEND) && rx_mode && rx_byte_vld);
  assign loading = (nxt_st == ST_SEND) && !nxt_nxt;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      st_ff   <= ST_IDLE;
      dir_ff  <= 1'b0;
      nxt_ff  <= 1'b0;
      data_ff <= 8'h00;
      last_ff <= 8'h00;
    end else begin
      st_ff  <= nxt_st;
      dir_ff <= nxt_dir;
      nxt_ff <= nxt_nxt;
      if (nxt_st == ST_SEND && !nxt_nxt) begin
        data_ff <= cur_cmd;
        last_ff <= cur_cmd;
      end else if (nxt_nxt && nxt_st == ST_SEND) begin
        data_ff <= rx_byte;
      end else begin
        data_ff <= 8'h00;
      end
    end
  end

  assign dir       = dir_ff;
  assign nxt       = nxt_ff;
  assign data_out  = data_ff;
  // The pad is driven only after the turn-around cycle.
  assign data_oe_n = !(dir_ff && st_ff == ST_SEND);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic wr_go;
  logic rd_go;
  logic [IRQ_W-1:0] irq_ev;
  logic [ALT_W-1:0] wclr;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign rd_go = s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign irq_ev = {ls_chg, vbid_chg, send_now && !nxt_ff};
  assign wclr   = (wr_go && s_axi_awaddr == ADDR_ALTINT && s_axi_wstrb[0]) ? s_axi_wdata[ALT_W-1:0] : '0;
  assign irq    = |(irq_st_ff & irq_mask_ff);

  logic [31:0] rd_mux;
  logic        rd_hit;
  assign rd_hit = s_axi_araddr <= ADDR_LAST && s_axi_araddr[1:0] == 2'h0;
  assign rd_mux = (s_axi_araddr == ADDR_CTRL)   ? ctrl_ff :
                  (s_axi_araddr == ADDR_STATUS) ? {24'h000000, cur_cmd} :
                  (s_axi_araddr == ADDR_IRQ)    ? {29'h0, irq_st_ff} :
                  (s_axi_araddr == ADDR_MASK)   ? {29'h0, irq_mask_ff} :
                  (s_axi_araddr == ADDR_ALTINT) ? {16'h0, alt_mask_ff, alt_latch_ff} :
                  (s_axi_araddr == ADDR_LAST)   ? {24'h000000, last_ff} : 32'h0;

  always_ff @(posedge core_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff      <= CTRL_RST;
      irq_st_ff    <= '0;
      irq_mask_ff  <= '0;
      alt_latch_ff <= '0;
      alt_mask_ff  <= '0;
      bvalid_ff    <= 1'b0;
      bresp_ff     <= RESP_OKAY;
      rvalid_ff    <= 1'b0;
      rdata_ff     <= 32'h0;
      rresp_ff     <= RESP_OKAY;
    end else begin
      // Hardware sets win over software clears.
      alt_latch_ff <= (alt_latch_ff & ~wclr) | alt_event;
      if (wr_go && s_axi_awaddr == ADDR_IRQ && s_axi_wstrb[0]) begin
        irq_st_ff <= (irq_st_ff & ~s_axi_wdata[IRQ_W-1:0]) | irq_ev;
      end else begin
        irq_st_ff <= irq_st_ff | irq_ev;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (s_axi_awaddr <= ADDR_LAST && s_axi_awaddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        if (s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0]) begin
          ctrl_ff <= {30'h0, s_axi_wdata[CTRL_STRT:CTRL_SYNC]};
        end
        if (s_axi_awaddr == ADDR_MASK && s_axi_wstrb[0]) begin
          irq_mask_ff <= s_axi_wdata[IRQ_W-1:0];
        end
        if (s_axi_awaddr == ADDR_ALTINT && s_axi_wstrb[1]) begin
          alt_mask_ff <= s_axi_wdata[2*ALT_W-1:ALT_W];
        end
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

endmodule

// ===== verilog/urg_pkg.sv
// Package with constants and types for the receive command generator.
package urg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ    = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0C;
  localparam logic [7:0] ADDR_ALTINT = 8'h10;
  localparam logic [7:0] ADDR_LAST   = 8'h14;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam int          CTRL_SYNC  = 0;
  localparam int          CTRL_STRT  = 1;
  localparam int          IRQ_W      = 3;
  localparam int          IRQ_SENT   = 0;
  localparam int          IRQ_VBID   = 1;
  localparam int          IRQ_LS     = 2;
  localparam int          ALT_W      = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] VB_LOW   = 2'h0;
  localparam logic [1:0] VB_SEND  = 2'h1;
  localparam logic [1:0] VB_SVLD  = 2'h2;
  localparam logic [1:0] VB_VVLD  = 2'h3;
  localparam logic [1:0] RX_IDLE  = 2'h0;
  localparam logic [1:0] RX_ACT   = 2'h1;
  localparam logic [1:0] RX_ERR   = 2'h3;
  localparam logic [1:0] RX_HDISC = 2'h2;

  typedef struct packed {
    logic       alt_int;
    logic       id;
    logic [1:0] rx_event;
    logic [1:0] vbus;
    logic [1:0] line_state;
  } urg_rxcmd_t;

  typedef struct packed {
    logic dp;
    logic dm;
    logic sess_end;
    logic sess_vld;
    logic vbus_vld;
    logic id;
    logic rx_active;
    logic rx_error;
    logic host_disc;
  } urg_status_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TURN = 2'b01,
    ST_SEND = 2'b10,
    ST_REL  = 2'b11
  } urg_state_t;

endpackage

// ===== verif/urg_link_model.sv
// Link-side model that drives stop and collects status bytes.
`timescale 1ns/10ps
module urg_link_model (
  input  wire logic       core_clk,
  input  wire logic       dir,
  input  wire logic       nxt,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  input  wire logic       stp_req,
  output logic            stp,
  output logic [7:0]      last_rx,
  output int              n_rx
);
  initial begin
    stp = 1'b0;
    last_rx = 8'h00;
    n_rx = 0;
  end
  // The turn cycle is skipped, since nobody drives the bus then.
  always @(posedge core_clk) begin
    stp <= stp_req;
    if (dir && !nxt && !data_oe_n) begin
      last_rx <= data_out;
      n_rx <= n_rx + 1;
    end
  end
endmodule

// ===== verif/urg_rxcmd_gen_chk.sv
// Concurrent checks on the receive command generator ports.
`timescale 1ns/10ps
module urg_rxcmd_gen_chk
  import urg_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire urg_status_t stat_in,
  input wire logic        tx_active,
  input wire logic        stp,
  input wire logic        dir,
  input wire logic        nxt,
  input wire logic [7:0]  data_out,
  input wire logic        data_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [1:0] vb;
  logic [1:0] ev;
  assign vb = stat_in.vbus_vld ? VB_VVLD : (stat_in.sess_vld ? VB_SVLD : (stat_in.sess_end ? VB_LOW : VB_SEND));
  assign ev = stat_in.host_disc ? RX_HDISC : (!stat_in.rx_active ? RX_IDLE : (stat_in.rx_error ? RX_ERR : RX_ACT));
  // Fields are only judged once the inputs have settled, as changes coalesce.
  sequence s_byte;
    $stable(stat_in)[*4] ##0 (!data_oe_n && !nxt);
  endsequence
  chk_oe_owns: assert property (!data_oe_n |-> dir && $past(dir))
    else $error("data driven without bus ownership");
  chk_turn_idle: assert property ($rose(dir) |-> data_oe_n)
    else $error("data driven in turn cycle");
  chk_line_send: assert property ($changed(stat_in.dp) && !dir && !tx_active |-> ##[1:3] dir)
    else $error("line change not sent");
  chk_ls_bits: assert property (s_byte |-> data_out[1:0] == {stat_in.dm, stat_in.dp})
    else $error("line state bits wrong");
  chk_vbus_bits: assert property (s_byte |-> data_out[3:2] == vb)
    else $error("vbus bits wrong");
  chk_event_bits: assert property (s_byte |-> data_out[5:4] == ev)
    else $error("event bits wrong");
  chk_id_bit: assert property (s_byte |-> data_out[6] == stat_in.id)
    else $error("id bit wrong");
  logic stp_in_tx_ff;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stp_in_tx_ff <= 1'b0;
    end else begin
      stp_in_tx_ff <= tx_active && (stp_in_tx_ff || stp);
    end
  end
  chk_tx_hold: assert property (tx_active && !dir && !stp_in_tx_ff |=> !dir)
    else $error("bus taken during transmit");
  chk_rx_cmd: assert property (dir && $past(dir) && !nxt |-> !data_oe_n)
    else $error("no status byte while owning bus");
  cover property ($rose(dir));
  cover property (dir && nxt);
  cover property (data_out[7] && !data_oe_n);
endmodule
bind urg_rxcmd_gen urg_rxcmd_gen_chk u_chk (.core_clk, .rstn, .stat_in, .tx_active, .stp, .dir, .nxt, .data_out, .data_oe_n);

// ===== verif/tb.sv
// Self-checking bench for the receive command generator.
`timescale 1ns/10ps
module tb;
  import urg_pkg::*;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  urg_status_t st = 9'h140;
  logic        tx_active = 1'b0;
  logic        mode_exit = 1'b0;
  logic        rx_start = 1'b0;
  logic        rx_byte_vld = 1'b0;
  logic [7:0]  alt_event = 8'h00;
  logic        stp_req = 1'b0;
  logic        stp, dir, nxt, data_oe_n, irq;
  logic [7:0]  data_out, last_rx, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          n_rx, err_count = 0, n_checks = 0, cyc = 0;
  urg_rxcmd_gen dut (.core_clk, .rstn, .stat_in(st), .tx_active, .mode_exit, .rx_start, .rx_byte_vld,
    .rx_byte(8'hA5), .alt_event, .stp, .dir, .nxt, .data_out, .data_oe_n, .irq, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  urg_link_model link (.core_clk, .dir, .nxt, .data_out, .data_oe_n, .stp_req, .stp, .last_rx, .n_rx);
  always #20 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Timeout ceiling is well above the few hundred cycles the tests need.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      report_and_stop;
    end
  end
  function automatic logic [31:0] enc(input urg_status_t s, input logic a);
    logic [1:0] v, e;
    v = s.vbus_vld ? VB_VVLD : (s.sess_vld ? VB_SVLD : (s.sess_end ? VB_LOW : VB_SEND));
    e = s.host_disc ? RX_HDISC : (!s.rx_active ? RX_IDLE : (s.rx_error ? RX_ERR : RX_ACT));
    return {24'h0, a, s.id, e, v, s.dm, s.dp};
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge core_clk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge core_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, RESP_OKAY);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", rresp, r);
    if (r == RESP_OKAY)
      chk("rdata", rdata, e);
  endtask
  task automatic apply(input urg_status_t s, input logic a, input logic [7:0] ev);
    int c;
    c = n_rx;
    st <= s;
    alt_event <= ev;
    @(posedge core_clk);
    alt_event <= 8'h00;
    for (int i = 0; i < 16 && n_rx == c; i++) @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    chk("rxcmd", last_rx, enc(s, a));
  endtask
  task automatic t_fields;
    urg_status_t tv [7] = '{9'h080, 9'h0A0, 9'h0B8, 9'h0BC, 9'h0BE, 9'h0B9, 9'h140};
    foreach (tv[i]) apply(tv[i], 1'b0, 8'h00);
    axr(ADDR_STATUS, enc(st, 1'b0), RESP_OKAY);
    axr(ADDR_LAST, enc(st, 1'b0), RESP_OKAY);
    axr(ADDR_CTRL, CTRL_RST, RESP_OKAY);
    axr(8'h18, 32'h0, RESP_SLVERR);
    $display("t_fields done");
  endtask
  task automatic t_tx;
    int c;
    tx_active <= 1'b1;
    @(posedge core_clk);
    c = n_rx;
    st <= 9'h040;
    repeat (8) @(posedge core_clk);
    chk("tx_hold", n_rx, c);
    stp_req <= 1'b1;
    @(posedge core_clk);
    stp_req <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("tx_send", last_rx, enc(9'h040, 1'b0));
    tx_active <= 1'b0;
    mode_exit <= 1'b1;
    c = n_rx;
    stp_req <= 1'b1;
    @(posedge core_clk);
    stp_req <= 1'b0;
    repeat (8) @(posedge core_clk);
    mode_exit <= 1'b0;
    chk("exit_send", n_rx != c, 1'b1);
    $display("t_tx done");
  endtask
  task automatic t_rx;
    rx_start <= 1'b1;
    st <= 9'h044;
    @(posedge core_clk);
    rx_start <= 1'b0;
    for (int i = 0; i < 8 && !(dir === 1'b1 && nxt === 1'b1); i++) @(posedge core_clk);
    chk("rx_take", {dir, nxt}, 2'b11);
    rx_byte_vld <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("rx_data", {nxt, data_out}, {1'b1, 8'hA5});
    rx_byte_vld <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("rx_oe", {dir, nxt, data_oe_n}, 3'b100);
    chk("rx_cmd", data_out, enc(9'h044, 1'b0));
    apply(9'h140, 1'b0, 8'h00);
    $display("t_rx done");
  endtask
  task automatic t_alt;
    apply(9'h140, 1'b1, 8'h01);
    axr(ADDR_ALTINT, 32'h1, RESP_OKAY);
    axw(ADDR_ALTINT, 32'h1);
    apply(9'h140, 1'b0, 8'h00);
    axw(ADDR_ALTINT, 32'h200);
    apply(9'h140, 1'b0, 8'h02);
    axw(ADDR_MASK, 32'h7);
    chk("irq_on", irq, 1'b1);
    axw(ADDR_MASK, 32'h0);
    chk("irq_mask", irq, 1'b0);
    axw(ADDR_IRQ, 32'h7);
    axr(ADDR_IRQ, 32'h0, RESP_OKAY);
    axw(ADDR_MASK, 32'h7);
    chk("irq_clr", irq, 1'b0);
    $display("t_alt done");
  endtask
  task automatic t_start;
    for (int i = 0; i < 16 && n_rx == 0; i++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    chk("startup", last_rx, enc(9'h140, 1'b0));
    chk("start_once", n_rx, 1);
    $display("t_start done");
  endtask
  task automatic t_sync;
    int c;
    axw(ADDR_CTRL, 32'h0);
    c = n_rx;
    st <= 9'h160;
    repeat (2) @(posedge core_clk);
    st <= 9'h170;
    repeat (8) @(posedge core_clk);
    chk("sync_off", n_rx, c);
    axw(ADDR_CTRL, 32'h1);
    repeat (8) @(posedge core_clk);
    chk("sync_one", n_rx - c, 1);
    chk("sync_byte", last_rx, enc(9'h170, 1'b0));
    axr(ADDR_CTRL, 32'h1, RESP_OKAY);
    $display("t_sync done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    t_start;
    t_fields;
    t_tx;
    t_rx;
    t_alt;
    t_sync;
    report_and_stop;
  end
endmodule
